//--- hdl/emc_map.svh
`ifndef EMC_MAP_SVH
`define EMC_MAP_SVH
// software registers of the controller (word addresses)
`define EMC_ADDR_CTRL 4'h0
`define EMC_ADDR_CFG 4'h1
`define EMC_ADDR_STATUS 4'h2
`define EMC_ADDR_LAT 4'h3
// ctrl register bits
`define EMC_CTRL_LOAD 0
`define EMC_CTRL_DLL_RESET 1
`define EMC_CTRL_SELF_REFRESH 2
`define EMC_CTRL_ODT_REQ 3
// extended configuration field positions
`define EMC_DLL_BIT 0
`define EMC_DRIVE_BIT 1
`define EMC_TERM_LO_BIT 2
`define EMC_AL_LSB 3
`define EMC_TERM_HI_BIT 6
`define EMC_CAL_LSB 7
`define EMC_CSTROBE_BIT 10
`define EMC_RSTROBE_BIT 11
`define EMC_OUTDIS_BIT 12
`define EMC_VALID_MASK 13'h1C7F
`define EMC_CFG_RESET 13'h0000
// dll taken as off before the first load, so the first enable gets a reset
`define EMC_SHADOW_RESET 13'h0001
// bank select and base mode operand with dll reset
`define EMC_BANK_EXT 3'h1
`define EMC_BANK_BASE 3'h0
`define EMC_BASE_DLL_RESET 13'h0100
// timing counts in clocks
`define EMC_MRD_CYCLES 8'h02
`define EMC_DLL_LOCK_CYCLES 8'hC8
`define EMC_AL_MAX 3'h4
`define EMC_CL_MIN 3'h3
`define EMC_CL_MAX 3'h5
`endif

//--- hdl/emc_pkg.sv
package emc_pkg;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank;
        logic [12:0] addr;
    } mem_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXT = 3'b001,
        ST_WAIT = 3'b010,
        ST_DLLRST = 3'b011,
        ST_LOCK = 3'b100
    } state_type;
endpackage

//--- hdl/ext_mode_ctrl.sv
// Notes on behaviour
// [RL1] device updates extended register only on selecting mode load; keeps it
// [RL2] load only with banks idle and no burst; then wait mode-set delay
// [RL3] bit zero enables DLL; keep enabled in normal use and at power-up
// [RL4] enabling DLL is followed by a mode load that resets the DLL
// [RL5] device disables DLL in self refresh, re-enables and resets on exit
// [RL6] after DLL enable and reset wait 200 clocks before any read
// [RL7] drive field zero gives full strength, one about 60 percent
// [RL8] complement strobe disable zero gives inverse strobe, one single-ended
// [RL9] complement disable also gates redundant complement strobe
// [RL10] redundant strobe enable drives redundant strobe during reads only
// [RL11] output disable one turns off all data and strobe outputs
// [RL12] termination bits two and six select value; no reserved codes; the code refuses the code with both bits set
// [RL13] termination input acts only when enabled and in active states
// [RL14] termination ignored in self refresh; keep it disabled there
// [RL15] keep termination off until extended register enables it
// [RL16] driver calibration field always programmed to default
// [RL17] additive latency bits three to five, zero to four only
// [RL18] early read or write allowed when additive latency within delay
// [RL19] read latency equals additive plus CAS latency
// [RL20] write latency is read latency minus one
// [RL21] CAS latency is 3, 4 or 5 clocks
// [RL22] bank lines choose which extended register takes the operand
// [RL23] unassigned extended bits written as zero
`include "emc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ext_mode_ctrl (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic banks_idle_in,
    output logic [15:0] rdata_out,
    output emc_pkg::mem_cmd_type cmd_out,
    output logic odt_out,
    output logic read_allowed_out,
    output logic busy_out
);
    // ========================================================
    // software registers
    logic [12:0] cfg, next_cfg;
    logic [12:0] shadow, next_shadow;
    logic [2:0] cas_lat, next_cas_lat;
    logic load_req, next_load_req;
    logic dll_rst_req, next_dll_rst_req;
    logic self_ref, next_self_ref;
    logic odt_req, next_odt_req;
    logic bad_code, next_bad_code;
    logic [15:0] next_rdata;
    logic [2:0] al_f;
    logic [1:0] term_f;
    emc_pkg::state_type state, next_state;
    logic load_started;
    always_comb begin
        next_cfg = cfg;
        next_cas_lat = cas_lat;
        next_load_req = load_req;
        next_dll_rst_req = dll_rst_req;
        next_self_ref = self_ref;
        next_odt_req = odt_req;
        next_bad_code = bad_code;
        next_rdata = 16'h0000;
        al_f = wdata_in[`EMC_AL_LSB +: 3];
        term_f = {wdata_in[`EMC_TERM_HI_BIT], wdata_in[`EMC_TERM_LO_BIT]};
        // requests consumed by the sequencer; a write in the same cycle wins
        if (load_started)
            next_load_req = 1'b0;
        if (state == emc_pkg::ST_EXT)
            next_dll_rst_req = 1'b0;
        if (wr_in) begin
            case (addr_in)
                `EMC_ADDR_CTRL: begin
                    if (wdata_in[`EMC_CTRL_LOAD])
                        next_load_req = 1'b1;
                    if (wdata_in[`EMC_CTRL_DLL_RESET])
                        next_dll_rst_req = 1'b1;
                    next_self_ref = wdata_in[`EMC_CTRL_SELF_REFRESH];
                    next_odt_req = wdata_in[`EMC_CTRL_ODT_REQ];
                end
                `EMC_ADDR_CFG: begin
                    // reserved codes refused, rest forced to zero
                    if (al_f > `EMC_AL_MAX || term_f == 2'b11) begin // RL12 RL17 RL18
                        next_bad_code = 1'b1;
                    end else begin
                        next_bad_code = 1'b0;
                        next_cfg = wdata_in[12:0] & `EMC_VALID_MASK; // RL16 RL23
                    end
                end
                `EMC_ADDR_LAT: begin
                    if (wdata_in[2:0] >= `EMC_CL_MIN &&
                        wdata_in[2:0] <= `EMC_CL_MAX)
                        next_cas_lat = wdata_in[2:0]; // RL21
                end
                default: begin
                end
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                `EMC_ADDR_CTRL: next_rdata = {12'h000, odt_req, self_ref,
                    dll_rst_req, load_req};
                `EMC_ADDR_CFG: next_rdata = {3'h0, cfg};
                `EMC_ADDR_STATUS: next_rdata = {bad_code, shadow,
                    read_allowed_out, busy_out};
                `EMC_ADDR_LAT: next_rdata = {5'h00,
                    4'(4'(cfg[`EMC_AL_LSB +: 3]) + 4'(cas_lat) - 4'h1),
                    4'(4'(cfg[`EMC_AL_LSB +: 3]) + 4'(cas_lat)),
                    cas_lat}; // RL19 RL20
                default: next_rdata = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg <= `EMC_CFG_RESET; // RL3
            cas_lat <= `EMC_CL_MIN;
            load_req <= 1'b0;
            dll_rst_req <= 1'b0;
            self_ref <= 1'b0;
            odt_req <= 1'b0;
            bad_code <= 1'b0;
            rdata_out <= 16'h0000;
        end else begin
            cfg <= next_cfg;
            cas_lat <= next_cas_lat;
            load_req <= next_load_req;
            dll_rst_req <= next_dll_rst_req;
            self_ref <= next_self_ref;
            odt_req <= next_odt_req;
            bad_code <= next_bad_code;
            rdata_out <= next_rdata;
        end
    end
    // ========================================================
    // command sequencer
    emc_pkg::state_type after_wait, next_after_wait;
    emc_pkg::mem_cmd_type next_cmd;
    logic [7:0] count, next_count;
    logic next_busy, next_read_allowed, next_odt;
    logic term_on;
    assign load_started = state == emc_pkg::ST_IDLE && load_req &&
        banks_idle_in && !self_ref;
    assign term_on = |{shadow[`EMC_TERM_HI_BIT], shadow[`EMC_TERM_LO_BIT]};
    always_comb begin
        next_state = state;
        next_after_wait = after_wait;
        next_count = count;
        next_shadow = shadow;
        next_cmd = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
            bank: 3'h0, addr: 13'h0000};
        next_read_allowed = read_allowed_out;
        case (state)
            emc_pkg::ST_IDLE: begin
                if (load_started) begin // RL2
                    next_state = emc_pkg::ST_EXT;
                end
            end
            emc_pkg::ST_EXT: begin
                next_cmd = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0,
                    we_n: 1'b0, bank: `EMC_BANK_EXT, addr: cfg}; // RL22
                next_shadow = cfg;
                next_count = `EMC_MRD_CYCLES;
                // a dll enable is always followed by a dll reset
                next_after_wait = (cfg[`EMC_DLL_BIT] == 1'b0 &&
                    (dll_rst_req || shadow[`EMC_DLL_BIT]))
                    ? emc_pkg::ST_DLLRST : emc_pkg::ST_IDLE; // RL4
                if (cfg[`EMC_DLL_BIT] == 1'b0 && shadow[`EMC_DLL_BIT])
                    next_read_allowed = 1'b0;
                next_state = emc_pkg::ST_WAIT;
            end
            emc_pkg::ST_WAIT: begin
                next_count = count - 8'h01;
                if (count == 8'h01) begin // RL2
                    next_state = after_wait;
                end
            end
            emc_pkg::ST_DLLRST: begin
                next_cmd = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0,
                    we_n: 1'b0, bank: `EMC_BANK_BASE,
                    addr: `EMC_BASE_DLL_RESET}; // RL4
                next_read_allowed = 1'b0;
                next_count = `EMC_DLL_LOCK_CYCLES;
                next_state = emc_pkg::ST_LOCK;
            end
            emc_pkg::ST_LOCK: begin
                next_count = count - 8'h01;
                if (count == 8'h01) begin
                    next_read_allowed = 1'b1; // RL6
                    next_state = emc_pkg::ST_IDLE;
                end
            end
            default: next_state = emc_pkg::ST_IDLE;
        endcase
        next_busy = next_state != emc_pkg::ST_IDLE;
        // termination off in self refresh and until enabled
        next_odt = odt_req && term_on && !self_ref; // RL14 RL15
    end
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= emc_pkg::ST_IDLE;
            after_wait <= emc_pkg::ST_IDLE;
            count <= 8'h00;
            shadow <= `EMC_SHADOW_RESET;
            cmd_out <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                bank: 3'h0, addr: 13'h0000};
            read_allowed_out <= 1'b0;
            busy_out <= 1'b0;
            odt_out <= 1'b0;
        end else begin
            state <= next_state;
            after_wait <= next_after_wait;
            count <= next_count;
            shadow <= next_shadow;
            cmd_out <= next_cmd;
            read_allowed_out <= next_read_allowed;
            busy_out <= next_busy;
            odt_out <= next_odt;
        end
    end
    // ========================================================
    // checks
    a_mrd_gap: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (state == emc_pkg::ST_EXT) |=> cmd_out.cs_n == 1'b0 ##1
        cmd_out.cs_n [*2]) else $error("command inside mode delay"); // RL2
    a_ext_bank: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (state == emc_pkg::ST_EXT) |=> cmd_out.bank == `EMC_BANK_EXT)
        else $error("wrong bank on extended load"); // RL22
    a_dll_follow: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (state == emc_pkg::ST_EXT && next_after_wait == emc_pkg::ST_DLLRST &&
        next_state == emc_pkg::ST_WAIT) |-> ##[1:4]
        (state == emc_pkg::ST_DLLRST))
        else $error("dll enable without reset"); // RL4
    a_lock_wait: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (state == emc_pkg::ST_DLLRST) |=> !read_allowed_out [*8])
        else $error("read allowed too early"); // RL6
    a_odt_sref: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $past(self_ref) |-> !odt_out)
        else $error("termination on in self refresh"); // RL14
    a_odt_init: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        odt_out |-> $past(term_on))
        else $error("termination before enable"); // RL15
    a_no_reserved: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        !cmd_out.cs_n && cmd_out.bank == `EMC_BANK_EXT |->
        cmd_out.addr[`EMC_AL_LSB +: 3] <= `EMC_AL_MAX &&
        cmd_out.addr[9:7] == 3'h0 && cmd_out.addr[12:0] ==
        (cmd_out.addr[12:0] & `EMC_VALID_MASK))
        else $error("reserved code sent"); // RL16 RL17 RL23
    a_dll_power_up: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        $fell(sys_rst_in) |-> cfg[`EMC_DLL_BIT] == 1'b0)
        else $error("dll off at power-up"); // RL3
    a_cl_range: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        cas_lat >= `EMC_CL_MIN && cas_lat <= `EMC_CL_MAX)
        else $error("cas latency out of range"); // RL21
endmodule
`default_nettype wire

//--- test/emc_dev_model.sv
`include "emc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module emc_dev_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire emc_pkg::mem_cmd_type cmd_in,
    input wire logic odt_in,
    output logic [12:0] ext_cfg_out,
    output logic [15:0] lock_count_out,
    output logic term_on_out,
    output logic dll_on_out,
    output logic drive_low_out,
    output logic cstrobe_on_out,
    output logic rstrobe_on_out
);
    logic mode_load;
    // ========
    // command decode and register load
    assign mode_load = !cmd_in.cs_n && !cmd_in.ras_n && !cmd_in.cas_n
        && !cmd_in.we_n;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_cfg_out <= 13'h0000;
            lock_count_out <= 16'h0000;
        end else begin
            if (mode_load && cmd_in.bank == `EMC_BANK_EXT) begin
                ext_cfg_out <= cmd_in.addr;
            end
            if (mode_load && cmd_in.bank == `EMC_BANK_BASE
                && cmd_in.addr[8]) begin
                // clocks that will have passed at the next edge
                lock_count_out <= 16'h0001;
            end else if (lock_count_out != 16'hFFFF) begin
                lock_count_out <= lock_count_out + 16'h0001;
            end
        end
    end
    // ========
    // output behaviour chosen by the fields
    assign dll_on_out = !ext_cfg_out[0];
    assign drive_low_out = ext_cfg_out[1];
    assign cstrobe_on_out = !ext_cfg_out[10] && !ext_cfg_out[12];
    assign rstrobe_on_out = ext_cfg_out[11] && !ext_cfg_out[12];
    assign term_on_out = odt_in && (ext_cfg_out[2] || ext_cfg_out[6]);
endmodule
`default_nettype wire

//--- test/ext_mode_ctrl_tb.sv
`include "emc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ext_mode_ctrl_tb;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b1;
    logic rd_pend = 1'b0;
    logic [15:0] rdata, lock;
    logic odt, ra, busy, term;
    logic [12:0] cfg, ext;
    logic [3:0] rl;
    logic [2:0] al, cl;
    emc_pkg::mem_cmd_type cmd;
    logic [15:0] exp_q[$];
    logic [15:0] mask_q[$];
    int mismatches = 0;
    int checks_done = 0;
    ext_mode_ctrl uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .banks_idle_in(idle), .rdata_out(rdata), .cmd_out(cmd),
        .odt_out(odt), .read_allowed_out(ra), .busy_out(busy));
    emc_dev_model dev (.clk_in(sys_clk_in), .rst_in(sys_rst_in),
        .cmd_in(cmd), .odt_in(odt), .ext_cfg_out(ext),
        .lock_count_out(lock), .term_on_out(term), .dll_on_out(),
        .drive_low_out(), .cstrobe_on_out(), .rstrobe_on_out());
    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // ========
    // bus tasks and scoring
    task check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [15:0] w, input logic [15:0] m);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(w);
        mask_q.push_back(m);
        @(posedge sys_clk_in);
        rd <= 1'b0;
    endtask
    task wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        while (busy !== 1'b0 && n < 400) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n >= 400) mismatches++;
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        if (rd_pend) begin
            check(rdata & mask_q.pop_front(), exp_q.pop_front());
        end
        rd_pend <= rd;
    end
    initial begin
        repeat (6000) @(posedge sys_clk_in);
        mismatches++;
        stop_test();
    end
    // ========
    // scenarios
    initial begin
        void'($urandom(9686));
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rd_reg(`EMC_ADDR_STATUS, {1'b0, `EMC_SHADOW_RESET, 2'b00}, 16'hFFFF);
        rd_reg(`EMC_ADDR_LAT, 16'h011B, 16'h07FF);
        rd_reg(4'hF, 16'h0000, 16'hFFFF);
        wr_reg(`EMC_ADDR_CTRL, 16'h0008);
        repeat (3) @(posedge sys_clk_in);
        check({15'h0, odt}, 16'h0000);
        idle <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            al = 3'($urandom_range(4, 0));
            cfg = 13'($urandom) & `EMC_VALID_MASK;
            cfg[5:3] = al;
            cfg[0] = 1'b0;
            if (cfg[2]) cfg[6] = 1'b0;
            wr_reg(`EMC_ADDR_CFG, {3'h0, cfg});
            wr_reg(`EMC_ADDR_CTRL, 16'h0003);
            if (i == 0) begin
                repeat (10) @(posedge sys_clk_in);
                check({15'h0, busy}, 16'h0000);
                check({3'h0, ext}, 16'h0000);
                idle <= 1'b1;
            end
            wait_idle();
            check({3'h0, ext}, {3'h0, cfg});
            check({15'h0, ra}, 16'h0001);
            check({15'h0, lock >= 16'h00C8}, 16'h0001);
            rd_reg(`EMC_ADDR_STATUS, 16'h0002, 16'h8003);
            cl = 3'(3 + i % 3);
            rl = {1'b0, al} + {1'b0, cl};
            wr_reg(`EMC_ADDR_LAT, {13'h0, cl});
            rd_reg(`EMC_ADDR_LAT, {5'h0, rl - 4'h1, rl, cl}, 16'h07FF);
        end
        for (int b = 0; b < 2; b++) begin
            wr_reg(`EMC_ADDR_CFG, (b != 0) ? 16'h0044 : 16'h0028);
            rd_reg(`EMC_ADDR_STATUS, 16'h8002, 16'h8003);
            wr_reg(`EMC_ADDR_LAT, (b != 0) ? 16'h0006 : 16'h0002);
            rd_reg(`EMC_ADDR_LAT, {5'h0, rl - 4'h1, rl, cl}, 16'h07FF);
        end
        wr_reg(`EMC_ADDR_CFG, 16'h0004);
        rd_reg(`EMC_ADDR_STATUS, 16'h0002, 16'h8003);
        wr_reg(`EMC_ADDR_CTRL, 16'h0001);
        wait_idle();
        check({3'h0, ext}, 16'h0004);
        wr_reg(`EMC_ADDR_CFG, 16'h0040);
        wr_reg(`EMC_ADDR_CTRL, 16'h000D);
        repeat (8) @(posedge sys_clk_in);
        check({15'h0, odt}, 16'h0000);
        check({3'h0, ext}, 16'h0004);
        wr_reg(`EMC_ADDR_CTRL, 16'h0008);
        repeat (3) @(posedge sys_clk_in);
        check({14'h0, odt, term}, 16'h0003);
        rd_reg(`EMC_ADDR_CTRL, 16'h0008, 16'h000F);
        wait_idle();
        check({3'h0, ext}, 16'h0040);
        repeat (3) @(posedge sys_clk_in);
        stop_test();
    end
endmodule
`default_nettype wire
